// ---- dv/psram_host_monitor.sv ----
/* Pin timing checker for psram_host.
 * Bound to the host; sees its ports only, 50 ns clock. */
`timescale 1ns/100ps
module psram_host_monitor #(
	parameter bit AUTO_A2 = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [20:0] mem_addr_o,
	input wire logic mem_select_n_o,
	input wire logic mem_write_n_o,
	input wire logic mem_out_en_n_o,
	input wire logic lower_byte_select_n_o,
	input wire logic upper_byte_select_n_o,
	input wire logic power_mode_pin_n_o,
	input wire logic dq_oe_o
);
	localparam int SEL_MAX = AUTO_A2 ? 40 : 160;
	logic [8:0] sel_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || mem_select_n_o) begin
			sel_cnt <= '0;
		end else begin
			sel_cnt <= sel_cnt + 9'h001;
		end
	end
	a_sel_low_max: assert property (sel_cnt <= SEL_MAX)
		else $error("select low too long");
	a_we_in_sel: assert property (!mem_write_n_o |->
		!mem_select_n_o && sel_cnt < SEL_MAX)
		else $error("write strobe outside select");
	a_addr_held: assert property (!mem_select_n_o &&
		!$past(mem_select_n_o) |-> $stable(mem_addr_o))
		else $error("address moved under select");
	a_wr_window: assert property ($fell(mem_write_n_o) |->
		(!mem_select_n_o && !mem_write_n_o) [*2])
		else $error("write pulse too short");
	a_bsel_window: assert property ($fell(mem_write_n_o) |->
		!(lower_byte_select_n_o && upper_byte_select_n_o) ##1
		$stable({lower_byte_select_n_o, upper_byte_select_n_o}))
		else $error("byte select window short");
	a_addr_setup: assert property ($rose(mem_write_n_o) |->
		$past(mem_addr_o, 2) == $past(mem_addr_o) &&
		!$past(mem_select_n_o, 2))
		else $error("address not set before write end");
	a_read_hold: assert property ($fell(mem_out_en_n_o) |->
		(!mem_select_n_o && mem_write_n_o) [*4] ##1 mem_select_n_o)
		else $error("read select length wrong");
	a_cfg_order: assert property ($fell(power_mode_pin_n_o) |->
		mem_select_n_o && $past(mem_select_n_o) ##1
		$fell(mem_write_n_o))
		else $error("config load order wrong");
	a_dq_drive: assert property (dq_oe_o ==
		(!mem_write_n_o && power_mode_pin_n_o))
		else $error("data drive outside write strobe");
	c_read: cover property ($fell(mem_out_en_n_o));
	c_write: cover property ($fell(mem_write_n_o) && power_mode_pin_n_o);
	c_config: cover property ($fell(power_mode_pin_n_o));
endmodule

// ---- dv/psram_model.sv ----
/* Behavioural async PSRAM, 256 words, plus a configuration word.
 * Assumes pins straight from host registers; no clock. */
`timescale 1ns/100ps
module psram_model #(
	// Slowest legal fast-grade access, so early sampling shows up
	parameter int ACC_NS = 60
) (
	input wire logic [20:0] addr_i,
	input wire logic select_n_i,
	input wire logic write_n_i,
	input wire logic out_en_n_i,
	input wire logic lower_n_i,
	input wire logic upper_n_i,
	input wire logic power_n_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	logic [15:0] mem [0:255];
	logic [20:0] cfg;
	logic [20:0] pa;
	logic [15:0] pd;
	logic [1:0] pl;
	logic pp;
	initial begin
		cfg = '0;
		dq_o = 16'h0000;
		for (int i = 0; i < 256; i++) begin
			mem[i] = {8'h5a, i[7:0]};
		end
	end
	always @(select_n_i, out_en_n_i, write_n_i, addr_i) begin
		if (!select_n_i && !out_en_n_i && write_n_i)
			dq_o <= #(ACC_NS) mem[addr_i[7:0]];
		else
			dq_o <= #1 ~dq_o;
	end
	// Capture while strobe low; pins all rise together
	always @(*) begin
		if (!select_n_i && !write_n_i) begin
			pa = addr_i;
			pd = dq_i;
			pl = {upper_n_i, lower_n_i};
			pp = power_n_i;
		end
	end
	always @(posedge write_n_i) begin
		if (!pp) begin
			cfg <= pa;
		end else begin
			if (!pl[0])
				mem[pa[7:0]][7:0] <= pd[7:0];
			if (!pl[1])
				mem[pa[7:0]][15:8] <= pd[15:8];
		end
	end
endmodule

// ---- dv/test_psram_host.sv ----
/* Self-checking bench for psram_host with a behavioural memory.
 * Assumes monitor and model are compiled before this file. */
`timescale 1ns/100ps
module test_psram_host;
	logic clk_i, rst_n_i, req_valid_i, req_write_i, req_config_i, rd_ready_i;
	logic [20:0] req_addr_i, mem_addr_o;
	logic [15:0] req_data_i, rd_data_o, dq_o, dq_i;
	logic [1:0] req_byte_en_i;
	logic req_ready_o, rd_valid_o, mem_select_n_o, mem_write_n_o;
	logic mem_out_en_n_o, lower_byte_select_n_o, upper_byte_select_n_o;
	logic power_mode_pin_n_o;
	int fail_count = 0;
	int samples_checked = 0;
	always #25 clk_i = ~clk_i;
	psram_host i_psram_host (.clk_i, .rst_n_i, .req_valid_i, .req_ready_o,
		.req_write_i, .req_config_i, .req_addr_i, .req_data_i,
		.req_byte_en_i, .rd_valid_o, .rd_data_o, .rd_ready_i, .mem_addr_o,
		.mem_select_n_o, .mem_write_n_o, .mem_out_en_n_o,
		.lower_byte_select_n_o, .upper_byte_select_n_o,
		.power_mode_pin_n_o, .dq_o, .dq_oe_o(), .dq_i);
	psram_model i_psram_model (.addr_i(mem_addr_o),
		.select_n_i(mem_select_n_o), .write_n_i(mem_write_n_o),
		.out_en_n_i(mem_out_en_n_o), .lower_n_i(lower_byte_select_n_o),
		.upper_n_i(upper_byte_select_n_o), .power_n_i(power_mode_pin_n_o),
		.dq_i(dq_o), .dq_o(dq_i));
	task automatic chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task automatic req(input logic w, c, input logic [20:0] a,
		input logic [15:0] d, input logic [1:0] be, output bit taken);
		int n;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_config_i <= c;
		req_addr_i <= a;
		req_data_i <= d;
		req_byte_en_i <= be;
		n = 0;
		taken = 1'b0;
		while (!taken && n < 40) begin
			@(posedge clk_i);
			n++;
			taken = (req_ready_o === 1'b1);
		end
		req_valid_i <= 1'b0;
	endtask
	task automatic wr(input logic [20:0] a, input logic [15:0] d,
		input logic [1:0] be);
		bit t;
		req(1'b1, 1'b0, a, d, be, t);
		chk("write taken", 32'h1, t);
	endtask
	task automatic rd(input logic [20:0] a, input logic [15:0] exp);
		bit t;
		int n;
		req(1'b0, 1'b0, a, 16'h0000, 2'b11, t);
		chk("read taken", 32'h1, t);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_valid_o !== 1'b1 && n < 40);
		chk("read data", exp, rd_data_o);
	endtask
	task automatic t_write_read;
		wr(21'h000010, 16'h1234, 2'b11);
		wr(21'h000011, 16'hbeef, 2'b11);
		rd(21'h000010, 16'h1234);
		rd(21'h000011, 16'hbeef);
		rd(21'h000012, 16'h5a12);
		$display("write_read done");
	endtask
	task automatic t_bytes;
		wr(21'h000020, 16'h1234, 2'b11);
		wr(21'h000020, 16'habcd, 2'b01);
		rd(21'h000020, 16'h12cd);
		wr(21'h000020, 16'h9900, 2'b10);
		rd(21'h000020, 16'h99cd);
		$display("bytes done");
	endtask
	task automatic t_config;
		bit t;
		req(1'b0, 1'b1, 21'h00a5a5, 16'hffff, 2'b11, t);
		chk("config taken", 32'h1, t);
		repeat (8) @(posedge clk_i);
		chk("config word", 32'h00a5a5, i_psram_model.cfg);
		chk("power pin idle", 32'h1, power_mode_pin_n_o);
		rd(21'h000020, 16'h99cd);
		$display("config done");
	endtask
	task automatic t_fifo_full;
		bit t;
		int cnt, got, n;
		cnt = 0;
		rd_ready_i <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			req(1'b0, 1'b0, 21'h000040 + i, 16'h0000, 2'b11, t);
			cnt += t;
		end
		chk("reads taken", 32'h11, cnt);
		rd_ready_i <= 1'b1;
		got = 0;
		n = 0;
		while (got < 17 && n < 100) begin
			@(posedge clk_i);
			n++;
			if (rd_valid_o === 1'b1) begin
				chk("fifo data", {24'h5a, 8'h40 + got[7:0]}, rd_data_o);
				got++;
			end
		end
		chk("words drained", 32'h11, got);
		@(posedge clk_i);
		chk("fifo empty", 32'h0, rd_valid_o);
		$display("fifo_full done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_write_i = 1'b0;
		req_config_i = 1'b0;
		req_addr_i = '0;
		req_data_i = '0;
		req_byte_en_i = 2'b00;
		rd_ready_i = 1'b1;
		repeat (2) @(posedge clk_i);
		chk("select in reset", 32'h1, mem_select_n_o);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_write_read;
		t_bytes;
		t_config;
		t_fifo_full;
		end_of_test;
	end
	initial begin
		#(3000 * 50);
		fail_count++;
		end_of_test;
	end
endmodule
bind psram_host psram_host_monitor #(.AUTO_A2(AUTO_A2)) i_psram_host_monitor (
	.clk_i, .rst_n_i, .mem_addr_o, .mem_select_n_o, .mem_write_n_o,
	.mem_out_en_n_o, .lower_byte_select_n_o, .upper_byte_select_n_o,
	.power_mode_pin_n_o, .dq_oe_o);

// ---- rtl/psram_host.sv ----
/*
 * Host-side cycle engine for a clockless async PSRAM: read, write and
 * configuration-load cycles, read data returned through a FIFO.
 * Assumes a 20 MHz clock, user requests on the same clock, dq from a pin.
 */
// Notes on behaviour
// - chip select never stays low beyond the grade's maximum select time.
// - write strobe low is bounded by that same maximum select time.
// - read address valid when select falls, held until select rises.
// - write and config address valid at select fall, held to select rise.
// - select stays low 55 or 70 ns before a write ends.
// - byte selects stay low 55 or 70 ns before a write ends.
// - address valid 55 or 70 ns before a write ends.
// - write strobe low at least 46 ns, high at least 10 ns between.
// - select high at least 5 ns between cycles.
// - deselect 5 ns before power pin low, strobe 10 to 500 ns later.
`timescale 1ns/100ps
`include "psram_host_params.svh"

module psram_host #(
	parameter bit FAST_GRADE = 1'b1,
	parameter bit AUTO_A2 = 1'b0,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic req_config_i,
	input wire logic [`ADDR_W-1:0] req_addr_i,
	input wire logic [`DATA_W-1:0] req_data_i,
	input wire logic [1:0] req_byte_en_i,
	output logic rd_valid_o,
	output logic [`DATA_W-1:0] rd_data_o,
	input wire logic rd_ready_i,
	output logic [`ADDR_W-1:0] mem_addr_o,
	output logic mem_select_n_o,
	output logic mem_write_n_o,
	output logic mem_out_en_n_o,
	output logic lower_byte_select_n_o,
	output logic upper_byte_select_n_o,
	output logic power_mode_pin_n_o,
	output logic [`DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	input wire logic [`DATA_W-1:0] dq_i
);
	localparam int ACC_NS = FAST_GRADE ? `T_ACCESS_FAST_NS
		: `T_ACCESS_SLOW_NS;
	localparam int WIN_NS = FAST_GRADE ? `T_WRITE_FAST_NS
		: `T_WRITE_SLOW_NS;
	localparam int ACC_CYC = `CYC_MIN(ACC_NS);
	localparam int OE_CYC = `CYC_MIN(`T_OE_ACCESS_NS);
	// Sampled data passes the synchroniser, so select stays low longer
	localparam int RD_CYC = (ACC_CYC > OE_CYC ? ACC_CYC : OE_CYC)
		+ `SYNC_STAGES;
	localparam int WIN_CYC = `CYC_MIN(WIN_NS);
	localparam int WP_CYC = `CYC_MIN(`T_WRITE_PULSE_NS);
	localparam int WR_CYC = WIN_CYC > WP_CYC ? WIN_CYC : WP_CYC;
	localparam int CPH_CYC = `CYC_MIN(`T_DESELECT_NS);
	localparam int WPH_CYC = `CYC_MIN(`T_WRITE_HIGH_NS);
	localparam int REC_CYC = CPH_CYC > WPH_CYC ? CPH_CYC : WPH_CYC;
	localparam int CDZZ_CYC = `CYC_MIN(`T_DESEL_TO_PWR_NS);
	localparam int ZZWE_CYC = `CYC_MIN(`T_PWR_TO_STROBE_MIN_NS);
	localparam int ZZWE_MAX_CYC = `CYC_MAX(`T_PWR_TO_STROBE_MAX_NS);
	localparam int CEM_CYC = `CYC_MAX((AUTO_A2 ? `T_SELECT_MAX_A2_US
		: `T_SELECT_MAX_IND_US) * 1000);

	psram_host_pkg::state_t state, next_state;
	psram_host_pkg::count_t cnt, next_cnt;
	psram_host_pkg::count_t low_cnt, next_low_cnt;
	logic is_read, next_is_read;
	logic [`ADDR_W-1:0] next_addr;
	logic [`DATA_W-1:0] next_dq;
	logic next_dq_oe;
	logic next_select_n, next_write_n, next_out_en_n, next_pwr_n;
	logic [1:0] next_bsel_n;
	logic next_req_ready;
	logic push_valid, next_push_valid;
	logic [`DATA_W-1:0] push_data, next_push_data;
	logic [`DATA_W-1:0] dq_meta, dq_sync;
	logic take, end_low;

	stream_if #(.WIDTH(`DATA_W)) fill_s ();

	assign fill_s.valid = push_valid;
	assign fill_s.data = push_data;

	read_fifo #(.WIDTH(`DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_s(fill_s),
		.out_valid_o(rd_valid_o),
		.out_data_o(rd_data_o),
		.out_ready_i(rd_ready_i)
	);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_is_read = is_read;
		next_addr = mem_addr_o;
		next_dq = dq_o;
		next_dq_oe = dq_oe_o;
		next_select_n = mem_select_n_o;
		next_write_n = mem_write_n_o;
		next_out_en_n = mem_out_en_n_o;
		next_pwr_n = power_mode_pin_n_o;
		next_bsel_n = {upper_byte_select_n_o, lower_byte_select_n_o};
		next_push_valid = 1'b0;
		next_push_data = push_data;
		take = req_valid_i && req_ready_o;
		// stop the cycle when its count ends or select has been low CEM_CYC cycles
		end_low = (cnt == '0) || (low_cnt == 9'(CEM_CYC - 1));
		next_low_cnt = mem_select_n_o ? '0 : low_cnt + 9'd1;
		case (state)
			psram_host_pkg::ST_IDLE: begin
				if (take) begin
					next_is_read = !req_write_i && !req_config_i;
					// address lands on the select falling edge, or on entry to ST_DESEL for config
					next_addr = req_addr_i;
					next_dq = req_data_i;
					if (req_config_i) begin
						next_state = psram_host_pkg::ST_DESEL;
						next_cnt = 9'(CDZZ_CYC - 1);
					end else begin
						next_state = psram_host_pkg::ST_ACCESS;
						next_select_n = 1'b0;
						next_bsel_n = ~req_byte_en_i;
						next_write_n = !req_write_i;
						next_out_en_n = req_write_i;
						next_dq_oe = req_write_i;
						next_cnt = 9'(req_write_i ? WR_CYC - 1 : RD_CYC - 1);
					end
				end
			end
			psram_host_pkg::ST_DESEL: begin
				// chip stays deselected before power pin falls
				if (cnt == '0) begin
					next_pwr_n = 1'b0;
					next_state = psram_host_pkg::ST_PWR_LOW;
					next_cnt = 9'(ZZWE_CYC - 1);
				end else begin
					next_cnt = cnt - 9'd1;
				end
			end
			psram_host_pkg::ST_PWR_LOW: begin
				// strobe falls inside the 10..500 ns window
				if (cnt == '0 || cnt >= 9'(ZZWE_MAX_CYC)) begin
					// configuration word valid as select falls
					next_select_n = 1'b0;
					next_write_n = 1'b0;
					next_bsel_n = 2'b00;
					next_state = psram_host_pkg::ST_ACCESS;
					next_cnt = 9'(WR_CYC - 1);
				end else begin
					next_cnt = cnt - 9'd1;
				end
			end
			psram_host_pkg::ST_ACCESS: begin
				// select, bytes and address stay for the window
				// address unchanged until the write ends
				// strobe low for the whole window
				// strobe rises no later than the select limit
				if (end_low) begin
					next_select_n = 1'b1;
					next_write_n = 1'b1;
					next_out_en_n = 1'b1;
					next_bsel_n = 2'b11;
					next_dq_oe = 1'b0;
					next_push_valid = is_read;
					next_push_data = dq_sync;
					next_state = psram_host_pkg::ST_RECOVER;
					next_cnt = 9'(REC_CYC - 1);
				end else begin
					next_cnt = cnt - 9'd1;
				end
			end
			psram_host_pkg::ST_RECOVER: begin
				// select and strobe high before the next cycle
				if (cnt == '0) begin
					next_pwr_n = 1'b1;
					next_state = psram_host_pkg::ST_IDLE;
				end else begin
					next_cnt = cnt - 9'd1;
				end
			end
			default: begin
				next_state = psram_host_pkg::ST_IDLE;
			end
		endcase
		// Reads reserve FIFO room up front so the push never stalls
		// A word still in flight to the FIFO is not yet in its count
		next_req_ready = (next_state == psram_host_pkg::ST_IDLE)
			&& fill_s.ready && !push_valid;
	end

	always_ff @(posedge clk_i) begin
		dq_meta <= dq_i;
		dq_sync <= dq_meta;
		if (!rst_n_i) begin
			state <= psram_host_pkg::ST_IDLE;
			cnt <= '0;
			low_cnt <= '0;
			is_read <= 1'b0;
			mem_addr_o <= '0;
			dq_o <= '0;
			dq_oe_o <= `RST_BUS;
			mem_select_n_o <= `RST_STROBE_N;
			mem_write_n_o <= `RST_STROBE_N;
			mem_out_en_n_o <= `RST_STROBE_N;
			power_mode_pin_n_o <= `RST_STROBE_N;
			lower_byte_select_n_o <= `RST_STROBE_N;
			upper_byte_select_n_o <= `RST_STROBE_N;
			req_ready_o <= 1'b0;
			push_valid <= 1'b0;
			push_data <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			low_cnt <= next_low_cnt;
			is_read <= next_is_read;
			mem_addr_o <= next_addr;
			dq_o <= next_dq;
			dq_oe_o <= next_dq_oe;
			mem_select_n_o <= next_select_n;
			mem_write_n_o <= next_write_n;
			mem_out_en_n_o <= next_out_en_n;
			power_mode_pin_n_o <= next_pwr_n;
			lower_byte_select_n_o <= next_bsel_n[0];
			upper_byte_select_n_o <= next_bsel_n[1];
			req_ready_o <= next_req_ready;
			push_valid <= next_push_valid;
			push_data <= next_push_data;
		end
	end
endmodule

// ---- rtl/psram_host_params.svh ----
/*
 * Timing figures, widths and reset levels of the async PSRAM host.
 * Assumes a single 50 ns system clock; times are kept in their own unit.
 */
`ifndef PSRAM_HOST_PARAMS_SVH
`define PSRAM_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define ADDR_W 21
`define DATA_W 16
`define FIFO_DEPTH 16
`define SYNC_STAGES 2

// Access and write-window figures per speed grade, then shared output-enable, strobe, deselect, power-pin and select-limit times
`define T_ACCESS_FAST_NS 60
`define T_ACCESS_SLOW_NS 70
`define T_OE_ACCESS_NS 20
`define T_WRITE_FAST_NS 55
`define T_WRITE_SLOW_NS 70
`define T_WRITE_PULSE_NS 46
`define T_WRITE_HIGH_NS 10
`define T_DESELECT_NS 5
`define T_DESEL_TO_PWR_NS 5
`define T_PWR_TO_STROBE_MIN_NS 10
`define T_PWR_TO_STROBE_MAX_NS 500
`define T_SELECT_MAX_IND_US 8
`define T_SELECT_MAX_A2_US 2

// Least times round up, longest times round down
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((ns) / `CLK_PERIOD_NS)

`define RST_BUS 1'b0
`define RST_STROBE_N 1'b1

`endif

// ---- rtl/psram_host_pkg.sv ----
/*
 * Types shared by the PSRAM host modules.
 * Assumes the constants header is included by the user files.
 */
package psram_host_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DESEL = 3'b001,
		ST_PWR_LOW = 3'b010,
		ST_ACCESS = 3'b011,
		ST_RECOVER = 3'b100
	} state_t;

	typedef logic [8:0] count_t;

endpackage

// ---- rtl/read_fifo.sv ----
/*
 * Read-data FIFO with a registered output stage.
 * Assumes DEPTH is a power of two; one clock, synchronous low reset.
 */
`timescale 1ns/100ps

module read_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	stream_if.snk in_s,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [CW-1:0] next_count;
	logic next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic push;
	logic load;

	// Honest full: the array alone, output stage is extra slack
	assign in_s.ready = (count != CW'(DEPTH));

	always_comb begin
		push = in_s.valid && in_s.ready;
		load = (count != '0) && (!out_valid_o || out_ready_i);
		next_wr_ptr = push ? wr_ptr + PW'(1) : wr_ptr;
		next_rd_ptr = load ? rd_ptr + PW'(1) : rd_ptr;
		next_count = count + CW'(push) - CW'(load);
		next_out_valid = load ? 1'b1 : (out_valid_o && !out_ready_i);
		next_out_data = load ? mem[rd_ptr] : out_data_o;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			out_valid_o <= next_out_valid;
			out_data_o <= next_out_data;
		end
		if (push) begin
			mem[wr_ptr] <= in_s.data;
		end
	end
endmodule

// ---- rtl/stream_if.sv ----
/*
 * Valid/ready word stream between the cycle engine and its read FIFO.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps

interface stream_if #(
	parameter int WIDTH = 16
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
